// >>> apf_defs.svh
`ifndef APF_DEFS_SVH
`define APF_DEFS_SVH

// Channel count and data widths
`define APF_NCH 2
`define APF_RES_W 24
`define APF_RES_FRAC 23
`define APF_RES_MAX 24'h7fffff
`define APF_RES_MIN 24'h800000
`define APF_CIC_W 32
`define APF_AVG_W 36
`define APF_EST_W 40
`define APF_EST_FRAC 16

// Modulator clock is the master clock divided by two
`define APF_MOD_DIV_LAST 1'h1

// Oversampling ratio selection: code 0 is 64, code 8 is 16384
`define APF_OSR_SEL_W 4
`define APF_OSR_SEL_1024 4'h4
`define APF_LOG_BASE 4'h6
`define APF_LOG3_MAX 4'ha
`define APF_PHASE_W 10

// Input select codes
`define APF_SEL_NORMAL 2'h0
`define APF_SEL_SHORT 2'h1
`define APF_SEL_TEST_POS 2'h2
`define APF_SEL_TEST_NEG 2'h3

// Test signal result, 2/15 of full scale
`define APF_TEST_CODE 24'h111111

// Fast-settling conversions after reset
`define APF_FAST_CONV 2'h2

// Data-ready low time
`define APF_CLK_NS 8
`define APF_CONVERSION_READY_N_LOW_NS 200
`define APF_CONVERSION_READY_N_LOW_CYC ((`APF_CONVERSION_READY_N_LOW_NS + `APF_CLK_NS - 1) / `APF_CLK_NS)
`define APF_CONVERSION_READY_N_CNT_W 8

`endif

// >>> apf_pkg.sv
`include "apf_defs.svh"

package apf_pkg;

   // Per-channel configuration word
   typedef struct packed {
      logic hpf_bypass;
      logic [1:0] input_select;
      logic [`APF_PHASE_W-1:0] phase_offset;
   } apf_cfg_s;

   typedef logic signed [`APF_RES_W-1:0] apf_res_t;

   // Per-channel filter state
   typedef struct packed {
      logic signed [`APF_CIC_W-1:0] i1;
      logic signed [`APF_CIC_W-1:0] i2;
      logic signed [`APF_CIC_W-1:0] i3;
      logic signed [`APF_CIC_W-1:0] c1;
      logic signed [`APF_CIC_W-1:0] c2;
      logic signed [`APF_CIC_W-1:0] c3;
      logic signed [`APF_CIC_W-1:0] snap;
      logic signed [`APF_AVG_W-1:0] avg;
      logic [3:0] avg_cnt;
      logic signed [`APF_EST_W-1:0] est;
      logic [1:0] conv_cnt;
      logic fresh;
      apf_res_t res;
   } apf_ch_s;

   // Whole block state
   typedef struct packed {
      logic [`APF_NCH-1:0] bits_meta;
      logic [`APF_NCH-1:0] bits_sync;
      logic div;
      logic [`APF_PHASE_W-1:0] mod_cnt;
      apf_ch_s [`APF_NCH-1:0] ch;
      logic conversion_ready_n_n;
      logic [`APF_CONVERSION_READY_N_CNT_W-1:0] conversion_ready_n_cnt;
   } apf_state_s;

endpackage : apf_pkg

// >>> apf_postfilter.sv
`timescale 1ns/10ps
// Overview of operation
// - Each channel decimates with a third-order sinc of length equal to the ratio, capped at 1024.
// - Nonzero shared cutoff code enables the DC-block filter; zero bypasses it.
// - Per-channel bypass bit disables the DC-block filter for that channel.
// - Cutoff code c gives coefficient 1/2^(c+1), applied as arithmetic shift.
// - DC-block state advances once per conversion result, never on time.
// - Per-channel 2-bit select routes positive or negative shared test signal.
// - Test signal yields plus or minus 2/15 full scale, gain independent.
// - Per-channel 10-bit two's complement phase in modulator cycles.
// - Each result after the first two spans exactly one ratio of samples; equal phases align windows.
// - Nonzero phase shifts that channel's window by the programmed cycles.
// - Phase range is -ratio/2 to ratio/2-1, fixed -512..511 above 1024.
// - Out-of-range phase saturates to the nearest limit.
// - Data-ready low timing follows the channels' phase-shifted results.
// - Ratios 2048 and up: sinc3 at 1024 then averaging of 2 to 16 outputs.
// - First two conversions after reset use sinc1, then sinc3 until reset.
`include "apf_defs.svh"
module apf_postfilter (
   input wire logic clk,
   input wire logic rst,
   input wire logic [`APF_NCH-1:0] mod_bits,
   input wire logic [`APF_OSR_SEL_W-1:0] osr_sel,
   input wire logic [3:0] hpf_cutoff_code,
   input wire apf_pkg::apf_cfg_s [`APF_NCH-1:0] chan_config_word,
   output logic [`APF_NCH-1:0][`APF_RES_W-1:0] chan_result,
   output logic conversion_ready_n
);
   import apf_pkg::*;

   apf_state_s s_r;
   apf_state_s s_nxt;
   logic tick;
   logic [3:0] log3;
   logic [3:0] mlog;
   logic [`APF_PHASE_W-1:0] cnt_mask;
   logic [`APF_NCH-1:0][`APF_PHASE_W-1:0] phase_clip;
   logic [`APF_NCH-1:0] win_end;
   logic [`APF_NCH-1:0] emit;
   apf_res_t [`APF_NCH-1:0] xval;
   logic all_fresh;

   // Clamp a wide value to the 24-bit result range
   function automatic apf_res_t sat24(input logic signed [63:0] v);
      if (v > 64'($signed(`APF_RES_MAX)))
         return `APF_RES_MAX;
      else if (v < 64'($signed(`APF_RES_MIN)))
         return `APF_RES_MIN;
      return v[`APF_RES_W-1:0];
   endfunction : sat24

   // Normalise a filter sum of gain 2^sh to a 24-bit fraction of full scale
   // Six-bit shift: sinc3 at 1024 plus 16-way averaging needs a shift of 34
   function automatic apf_res_t scale(input logic signed [`APF_AVG_W-1:0] v, input logic [5:0] sh);
      logic signed [63:0] w;
      w = (64'(v) <<< `APF_RES_FRAC) >>> sh;
      return sat24(w);
   endfunction : scale

   // Saturate a programmed phase to -2^(k-1) .. 2^(k-1)-1
   function automatic logic [`APF_PHASE_W-1:0] clip_phase(input logic [`APF_PHASE_W-1:0] ph, input logic [3:0] k);
      logic signed [10:0] half;
      logic signed [10:0] p;
      half = 11'(11'sh1 <<< (k - 4'h1));
      p = 11'($signed(ph));
      if (p > half - 11'sh1)
         p = half - 11'sh1;
      else if (p < -half)
         p = -half;
      return p[`APF_PHASE_W-1:0];
   endfunction : clip_phase

   // Ratio decode: sinc3 length capped at 1024, excess goes to averaging
   assign log3 = (osr_sel <= `APF_OSR_SEL_1024) ? 4'(`APF_LOG_BASE + osr_sel) : `APF_LOG3_MAX;
   assign mlog = (osr_sel <= `APF_OSR_SEL_1024) ? 4'h0 : 4'(osr_sel - `APF_OSR_SEL_1024);
   assign cnt_mask = 10'((11'h1 << log3) - 11'h1);
   assign tick = (s_r.div == `APF_MOD_DIV_LAST);

   // Next-state logic for the whole block
   always_comb
   begin
      logic signed [`APF_CIC_W-1:0] inc;
      logic signed [`APF_CIC_W-1:0] t1;
      logic signed [`APF_CIC_W-1:0] t2;
      logic signed [`APF_CIC_W-1:0] t3;
      logic signed [`APF_CIC_W-1:0] s1;
      logic signed [`APF_AVG_W-1:0] acc;
      logic signed [40:0] dlt;
      apf_res_t y;
      s_nxt = s_r;
      inc = '0;
      t1 = '0;
      t2 = '0;
      t3 = '0;
      s1 = '0;
      acc = '0;
      dlt = '0;
      y = '0;
      emit = '0;
      xval = '0;
      all_fresh = 1'b0;
      phase_clip = '0;
      win_end = '0;
      // Two-flop synchroniser on the modulator bit-streams
      s_nxt.bits_meta = mod_bits;
      s_nxt.bits_sync = s_r.bits_meta;
      s_nxt.div = tick ? 1'h0 : 1'h1;
      // Shared zero-phase reference count, one step per modulator cycle
      if (tick)
         s_nxt.mod_cnt = (s_r.mod_cnt + 10'h1) & cnt_mask;
      for (int c = 0; c < `APF_NCH; c++)
      begin
         phase_clip[c] = clip_phase(chan_config_word[c].phase_offset, log3);
         // Window closes where the reference count meets the channel phase
         win_end[c] = tick && (s_r.mod_cnt == (phase_clip[c] & cnt_mask));
         // Shorted or test-routed inputs feed zero into the integrators
         if (chan_config_word[c].input_select == `APF_SEL_NORMAL)
            inc = s_r.bits_sync[c] ? 32'sh1 : -32'sh1;
         else
            inc = 32'sh0;
         if (tick)
         begin
            // Integrator chain, wraps by design; combs undo the wrap
            s_nxt.ch[c].i1 = s_r.ch[c].i1 + inc;
            s_nxt.ch[c].i2 = s_r.ch[c].i2 + s_r.ch[c].i1;
            s_nxt.ch[c].i3 = s_r.ch[c].i3 + s_r.ch[c].i2;
         end
         if (win_end[c])
         begin
            // Comb chain at the decimated rate
            t1 = s_r.ch[c].i3 - s_r.ch[c].c1;
            t2 = t1 - s_r.ch[c].c2;
            t3 = t2 - s_r.ch[c].c3;
            s_nxt.ch[c].c1 = s_r.ch[c].i3;
            s_nxt.ch[c].c2 = t1;
            s_nxt.ch[c].c3 = t2;
            // First-order sum over the same window for fast settling
            s1 = s_r.ch[c].i1 - s_r.ch[c].snap;
            s_nxt.ch[c].snap = s_r.ch[c].i1;
            if (s_r.ch[c].conv_cnt < `APF_FAST_CONV)
            begin
               emit[c] = 1'b1;
               xval[c] = scale(36'(s1), 6'(log3));
               s_nxt.ch[c].conv_cnt = s_r.ch[c].conv_cnt + 2'h1;
            end
            else if (mlog == 4'h0)
            begin
               emit[c] = 1'b1;
               xval[c] = scale(36'(t3), 6'(3 * log3));
            end
            else
            begin
               // Averaging stage; gain of 2^mlog folded into the shift
               acc = s_r.ch[c].avg + 36'(t3);
               if (s_r.ch[c].avg_cnt == 4'((5'h1 << mlog) - 5'h1))
               begin
                  emit[c] = 1'b1;
                  xval[c] = scale(acc, 6'(3 * log3 + mlog));
                  s_nxt.ch[c].avg = '0;
                  s_nxt.ch[c].avg_cnt = 4'h0;
               end
               else
               begin
                  s_nxt.ch[c].avg = acc;
                  s_nxt.ch[c].avg_cnt = s_r.ch[c].avg_cnt + 4'h1;
               end
            end
            // Test signal replaces the filtered value at a gain-free level
            if (chan_config_word[c].input_select == `APF_SEL_TEST_POS)
               xval[c] = `APF_TEST_CODE;
            else if (chan_config_word[c].input_select == `APF_SEL_TEST_NEG)
               xval[c] = -`APF_TEST_CODE;
         end
         if (emit[c])
         begin
            // DC block: one update per result, so the corner tracks the data rate
            if (hpf_cutoff_code != 4'h0 && !chan_config_word[c].hpf_bypass)
            begin
               // Signed views throughout, or negative estimates would zero-extend
               y = sat24(64'(xval[c]) - 64'($signed(s_r.ch[c].est[`APF_EST_W-1:`APF_EST_FRAC])));
               dlt = 41'($signed({xval[c], 16'h0})) - 41'(s_r.ch[c].est);
               // Five-bit shift amount so code Fh reaches a shift of 16
               s_nxt.ch[c].est = s_r.ch[c].est + 40'(dlt >>> (5'(hpf_cutoff_code) + 5'h1));
            end
            else
               y = xval[c];
            s_nxt.ch[c].res = y;
            s_nxt.ch[c].fresh = 1'b1;
         end
      end
      // Data ready falls once every channel has a new result, so phases shift it
      all_fresh = &{s_nxt.ch[1].fresh, s_nxt.ch[0].fresh};
      if (all_fresh)
      begin
         s_nxt.conversion_ready_n_n = 1'b0;
         s_nxt.conversion_ready_n_cnt = 8'(`APF_CONVERSION_READY_N_LOW_CYC - 1);
         for (int c = 0; c < `APF_NCH; c++)
            s_nxt.ch[c].fresh = 1'b0;
      end
      else if (!s_r.conversion_ready_n_n)
      begin
         if (s_r.conversion_ready_n_cnt == 8'h0)
            s_nxt.conversion_ready_n_n = 1'b1;
         else
            s_nxt.conversion_ready_n_cnt = s_r.conversion_ready_n_cnt - 8'h1;
      end
   end

   // State register; data-ready idles high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.conversion_ready_n_n <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign conversion_ready_n = s_r.conversion_ready_n_n;
   always_comb
   begin
      for (int c = 0; c < `APF_NCH; c++)
         chan_result[c] = s_r.ch[c].res;
   end

   localparam int CONVERSION_READY_N_M1 = `APF_CONVERSION_READY_N_LOW_CYC - 1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence conversion_ready_n_low_run;
      !conversion_ready_n ##CONVERSION_READY_N_M1 !conversion_ready_n;
   endsequence

   sequence conversion_ready_n_release;
      ##1 conversion_ready_n;
   endsequence

   a_test_pos_level: assert property (
      emit[0] && chan_config_word[0].input_select == `APF_SEL_TEST_POS && hpf_cutoff_code == 4'h0
      |=> chan_result[0] == `APF_TEST_CODE)
      else $error("positive test level wrong");
   a_test_neg_level: assert property (
      emit[1] && chan_config_word[1].input_select == `APF_SEL_TEST_NEG && chan_config_word[1].hpf_bypass
      |=> chan_result[1] == -`APF_TEST_CODE)
      else $error("negative test level wrong");
   a_hpf_bypass_pass: assert property (
      emit[0] && (hpf_cutoff_code == 4'h0 || chan_config_word[0].hpf_bypass)
      |=> chan_result[0] == $past(xval[0]))
      else $error("bypassed filter altered result");
   a_phase_clip_hi: assert property (
      $signed(chan_config_word[0].phase_offset) >= $signed(11'h1 << (log3 - 4'h1))
      |-> $signed(phase_clip[0]) == $signed(11'((11'h1 << (log3 - 4'h1)) - 11'h1)))
      else $error("phase not saturated high");
   a_phase_clip_range: assert property (
      log3 == `APF_LOG3_MAX || ($signed(phase_clip[1]) < $signed(11'h1 << (log3 - 4'h1))
      && $signed(phase_clip[1]) >= -$signed(11'h1 << (log3 - 4'h1))))
      else $error("phase outside range");
   a_equal_phase_align: assert property (
      chan_config_word[0].phase_offset == chan_config_word[1].phase_offset |-> win_end[0] == win_end[1])
      else $error("equal phases not aligned");
   a_conversion_ready_n_fall_cause: assert property (
      $fell(conversion_ready_n) |-> $past(all_fresh))
      else $error("data ready fell without results");
   a_conversion_ready_n_pulse_width: assert property (
      $fell(conversion_ready_n) |-> conversion_ready_n_low_run ##0 conversion_ready_n_release)
      else $error("data ready low time wrong");
   a_fast_path_done: assert property (
      $past(s_r.ch[0].conv_cnt) == `APF_FAST_CONV |-> s_r.ch[0].conv_cnt == `APF_FAST_CONV)
      else $error("fast path re-entered");
   a_window_spacing: assert property (
      win_end[0] |=> !win_end[0] [*8])
      else $error("windows too close");

endmodule : apf_postfilter

// >>> apf_host_model.sv
`timescale 1ns/10ps
`include "apf_defs.svh"
module apf_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic conversion_ready_n,
   input wire logic [`APF_NCH-1:0][`APF_RES_W-1:0] chan_result,
   output logic [`APF_NCH-1:0][`APF_RES_W-1:0] rd_data,
   output logic [15:0] rd_cnt
);
   logic ready_q;

   // Host takes both channels at each falling edge of data ready
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ready_q <= 1'h1;
         rd_data <= '0;
         rd_cnt <= 16'h0;
      end
      else
      begin
         ready_q <= conversion_ready_n;
         if (ready_q && !conversion_ready_n)
         begin
            rd_data <= chan_result;
            // Whole-sample realignment between streams stays with the host
            rd_cnt <= rd_cnt + 16'h1;
         end
      end
   end
endmodule : apf_host_model

// >>> apf_postfilter_tb.sv
`timescale 1ns/10ps
`include "apf_defs.svh"
module apf_postfilter_tb;
   import apf_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [`APF_NCH-1:0] mod_bits = 2'h1;
   logic [`APF_OSR_SEL_W-1:0] osr_sel = 4'h0;
   logic [3:0] hpf_cutoff_code = 4'h0;
   apf_cfg_s [`APF_NCH-1:0] cfg = '0;
   logic [`APF_NCH-1:0][`APF_RES_W-1:0] chan_result;
   logic conversion_ready_n;
   logic [`APF_NCH-1:0][`APF_RES_W-1:0] rd_data;
   logic [15:0] rd_cnt;
   logic [3:0] ph_osr [9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h1, 4'h4, 4'h4};
   logic [9:0] ph_set [9] = '{10'h000, 10'h005, 10'h064, 10'h39c, 10'h3ff, 10'h000, 10'h064, 10'h000, 10'h200};
   int ph_q [9] = '{0, 5, 31, 32, 63, 0, 63, 0, 512};
   int failures = 0;
   int compares = 0;
   int cyc = 0;
   int t_a;
   int t_b;
   int base;
   int n2;
   real y;

   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   apf_postfilter u_apf_postfilter (.clk(clk), .rst(rst), .mod_bits(mod_bits), .osr_sel(osr_sel),
      .hpf_cutoff_code(hpf_cutoff_code), .chan_config_word(cfg), .chan_result(chan_result),
      .conversion_ready_n(conversion_ready_n));
   apf_host_model u_apf_host_model (.clk(clk), .rst(rst), .conversion_ready_n(conversion_ready_n),
      .chan_result(chan_result), .rd_data(rd_data), .rd_cnt(rd_cnt));

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (failures == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   // Six-cycle reset; the release cycle becomes the timing reference
   // Reset rises in the step of each new ratio or phase setting, so no odd window runs unreset
   task automatic restart();
      rst = 1'h1;
      repeat (6) @(posedge clk);
      #1;
      rst = 1'h0;
      t_a = cyc;
   endtask : restart

   // Bounded wait for n host reads; a hang here counts against the run
   task automatic wait_reads(input int n, output int stamp);
      int start;
      int guard;
      start = rd_cnt;
      guard = 0;
      while (int'(rd_cnt) - start < n && guard < 40000)
      begin
         @(posedge clk);
         #1;
         guard++;
      end
      if (guard >= 40000)
         failures++;
      stamp = cyc;
   endtask : wait_reads

   function automatic logic [23:0] sel_exp(input int s);
      if (s == 1)
         return 24'h0;
      if (s == 2)
         return `APF_TEST_CODE;
      return -`APF_TEST_CODE;
   endfunction : sel_exp

   initial
   begin
      // Constant streams: full positive on channel 0, full negative on channel 1
      restart();
      wait_reads(5, t_b);
      check(rd_data[0], `APF_RES_MAX);
      check(rd_data[1], `APF_RES_MIN);
      // Every non-normal select, filter kept out by cutoff code zero
      for (int s = 1; s < 4; s++)
      begin
         cfg[0].input_select = s[1:0];
         cfg[1].input_select = 2'(4 - s);
         wait_reads(4, t_b);
         check(rd_data[0], sel_exp(s));
         check(rd_data[1], sel_exp(4 - s));
      end
      // Each nonzero cutoff code: decay after three updates, channel 1 bypassed
      cfg[0].input_select = `APF_SEL_TEST_POS;
      cfg[1].input_select = `APF_SEL_TEST_NEG;
      cfg[1].hpf_bypass = 1'h1;
      for (int c = 1; c < 16; c++)
      begin
         hpf_cutoff_code = 4'h0;
         restart();
         wait_reads(3, t_b);
         hpf_cutoff_code = c[3:0];
         wait_reads(4, t_b);
         y = real'(`APF_TEST_CODE) * (1.0 - 1.0 / (2.0 ** (c + 1))) ** 3;
         check({23'h0, ($signed(rd_data[0]) - y) < 3.0 && ($signed(rd_data[0]) - y) > -3.0}, 24'h1);
         check(rd_data[1], -`APF_TEST_CODE);
      end
      // Negative level through the DC block on channel 1
      cfg[1].hpf_bypass = 1'h0;
      hpf_cutoff_code = 4'h0;
      restart();
      wait_reads(3, t_b);
      hpf_cutoff_code = 4'h1;
      wait_reads(4, t_b);
      y = -real'(`APF_TEST_CODE) * 0.421875;
      check({23'h0, ($signed(rd_data[1]) - y) < 3.0 && ($signed(rd_data[1]) - y) > -3.0}, 24'h1);
      // Equal phases: one result per ratio of modulator ticks, two clocks each
      hpf_cutoff_code = 4'h0;
      for (int c = 0; c < 6; c++)
      begin
         osr_sel = c[3:0];
         restart();
         wait_reads(4, t_a);
         wait_reads(1, t_b);
         check(24'(t_b - t_a), 24'(128 << c));
      end
      // Phase moves the data-ready fall; values beyond range clip to the limit
      for (int i = 0; i < 9; i++)
      begin
         osr_sel = ph_osr[i];
         cfg[0].phase_offset = ph_set[i];
         cfg[1].phase_offset = ph_set[i];
         n2 = 128 << ph_osr[i];
         restart();
         wait_reads(2, t_b);
         if (ph_q[i] == 0)
            base = t_b - t_a;
         check(24'(((t_b - t_a - base) % n2 + n2) % n2), 24'(2 * ph_q[i]));
      end
      report_and_stop();
   end

   // Watchdog sized well above the planned run
   initial
   begin
      repeat (100000) @(posedge clk);
      failures++;
      report_and_stop();
   end
endmodule : apf_postfilter_tb
